// ===== port_d_pkg.sv
/*
 * Shared constants for the port D pin function multiplexer: register byte
 * offsets on the APB slave, field positions and values after reset.
 * Assumes a 32-bit APB bus where each register takes one aligned word.
 */
package port_d_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_PIN_LEVELS   = 8'h00;
	localparam logic [7:0] OFS_OUT_LATCH    = 8'h04;
	localparam logic [7:0] OFS_DIRECTION    = 8'h08;
	localparam logic [7:0] OFS_PAD_PULLUP   = 8'h0c;
	localparam logic [7:0] OFS_OPEN_DRAIN   = 8'h10;
	localparam logic [7:0] OFS_ANALOG_UPPER = 8'h14;
	localparam logic [7:0] OFS_PAR_PORT_CTL = 8'h18;

	// field positions
	localparam int PAR_SLAVE_SEL_BIT  = 4;
	localparam int PORT_D_PULLUP_BIT  = 7;
	localparam int PORT_E_PULLUP_BIT  = 6;
	localparam int PORT_F_PULLUP_BIT  = 5;
	localparam int PORT_G_PULLUP_BIT  = 4;
	localparam int CUR_SRC_SEL_BIT    = 0;
	localparam int OD_COMPARE1_BIT    = 2;
	localparam int OD_SERIAL2_BIT     = 1;

	// pins of the upper half that carry peripheral functions
	localparam int PIN_CAPTURE = 4;
	localparam int PIN_PWM_B   = 5;
	localparam int PIN_TX_CLK  = 6;
	localparam int PIN_RX_DATA = 7;

	// values after reset
	localparam logic [7:0] DIRECTION_RST    = 8'hff;
	localparam logic [7:0] OUT_LATCH_RST    = 8'h00;
	localparam logic [7:0] PAD_PULLUP_RST   = 8'h80;
	localparam logic [7:0] OPEN_DRAIN_RST   = 8'h00;
	localparam logic [7:0] ANALOG_UPPER_RST = 8'h00;
	localparam logic [7:0] PAR_PORT_CTL_RST = 8'h00;
	localparam logic [7:0] PIN_LEVELS_RST   = 8'h00;

	// pad bits that can exist at all (bits 3..1 are reserved)
	localparam logic [7:0] PAD_MASK_64  = 8'hf1;
	localparam logic [7:0] PAD_MASK_44  = 8'hc1;
	localparam logic [7:0] PAD_MASK_28  = 8'h01;
	localparam logic [7:0] PAR_CTL_MASK = 8'h10;

endpackage : port_d_pkg

// ===== pin_sampler.sv
/*
 * Samples the pad input levels once per clock into a register.
 * Assumes pad inputs are already synchronous to pclk.
 */
`timescale 1ns/1ns
module pin_sampler
	import port_d_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// pad side
	input  wire logic [WIDTH-1:0] pad_in,
	// sampled levels
	output logic      [WIDTH-1:0] level_r
);

	// one register stage; peripherals and software read the same copy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_r <= WIDTH'(PIN_LEVELS_RST);
		else
			level_r <= pad_in;
	end

endmodule : pin_sampler

// ===== port_pin_cell.sv
/*
 * One pad cell: picks the driven value and the output enable from the port
 * latch, a peripheral function or the parallel slave bus, and gates the
 * weak pull-up. Outputs are registered.
 * Assumes the caller has already resolved which peripheral owns the pin.
 */
`timescale 1ns/1ns
module port_pin_cell
	import port_d_pkg::*;
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// software controls
	input  wire logic dir,
	input  wire logic latch,
	input  wire logic pullup_en,
	input  wire logic open_drain,
	// parallel slave bus
	input  wire logic psp_own,
	input  wire logic psp_drive,
	input  wire logic psp_out,
	// peripheral function
	input  wire logic fn_sel,
	input  wire logic fn_out,
	input  wire logic fn_force,
	input  wire logic fn_tristate,
	// pad
	output logic      pad_out_r,
	output logic      pad_oe_r,
	output logic      pad_pullup_r
);

	logic want_drive;
	logic value_nxt;
	logic oe_nxt;

	// bus owns the pin outright, direction bit is ignored
	assign want_drive = psp_own ? psp_drive : ((fn_sel && fn_force) || !dir);
	assign value_nxt  = psp_own ? psp_out : (fn_sel ? fn_out : latch);
	// open drain lets the pad float instead of driving high
	assign oe_nxt     = want_drive && !(!psp_own && fn_sel && fn_tristate)
	                    && !(!psp_own && open_drain && value_nxt);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_out_r    <= 1'b0;
			pad_oe_r     <= 1'b0;
			pad_pullup_r <= 1'b0;
		end
		else
		begin
			pad_out_r    <= value_nxt;
			pad_oe_r     <= oe_nxt;
			pad_pullup_r <= pullup_en && !oe_nxt;
		end
	end

endmodule : port_pin_cell

// ===== port_d_pin_function_mux.sv
/*
 * Port D pin function multiplexer with its APB register file: port latch,
 * direction, pad pull-up config, open drain, analog select and the parallel
 * port control. Upper pins carry compare/PWM and serial 2 functions.
 * Assumes peripherals give their enables and outputs synchronous to pclk,
 * and the pads resolve out/oe/pull-up into a pin level.
 */
// Decided for this implementation: the APB register port and the address map.
// How it works
// - each pin has its own direction bit; zero drives the latch onto it.
// - every reset leaves all port pins as digital inputs.
// - weak pull-up is removed whenever the pin drives.
// - parallel slave select bit 4 hands all eight pins to the slave bus.
// - pin 4 drives compare/PWM at direction zero, feeds capture at one.
// - pins 4 and 5 carry PWM A and B, may float on shutdown.
// - pins 6 and 7 carry PWM C and D, may float on shutdown.
// - pin 6 drives serial 2 transmit at direction zero, over the latch.
// - pin 6 is serial 2 clock, output at zero, input at one.
// - pin 7 feeds serial 2 receive when direction bit is one.
// - pin 7 carries sync data; transmit overrides, receive needs direction one.
// - under the slave bus, pins are bidirectional data, direction ignored.
// - serial 2 functions reach pins 6 and 7 only in 40 and 44 pin parts.
// - pad config holds pull-ups in bits 7..4, current source in bit 0.
`timescale 1ns/1ns
module port_d_pin_function_mux
	import port_d_pkg::*;
#(
	parameter int PIN_COUNT = 44
)
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pads
	input  wire logic [7:0]  pad_in,
	output logic      [7:0]  pad_out,
	output logic      [7:0]  pad_oe,
	output logic      [7:0]  pad_pullup,
	// compare/pwm unit
	input  wire logic        ccp_out_en,
	input  wire logic        ccp_out,
	input  wire logic [3:0]  pwm_en,
	input  wire logic [3:0]  pwm_out,
	input  wire logic        pwm_shutdown,
	input  wire logic [3:0]  pwm_tri_cfg,
	output logic             capture_in,
	// serial transceiver 2
	input  wire logic        s2_tx_en,
	input  wire logic        s2_tx,
	input  wire logic        s2_clk_out_en,
	input  wire logic        s2_clk_out,
	input  wire logic        s2_data_out_en,
	input  wire logic        s2_data_out,
	output logic             s2_rx,
	output logic             s2_clk_in,
	output logic             s2_data_in,
	// parallel slave bus
	input  wire logic        psp_drive,
	input  wire logic [7:0]  psp_data_out,
	output logic      [7:0]  psp_data_in,
	output logic             psp_mode,
	// pad controls for other blocks
	output logic             current_source_select
);

	// elaboration check; no other package variant has a pad mask
	if (PIN_COUNT != 28 && PIN_COUNT != 40 && PIN_COUNT != 44 && PIN_COUNT != 64)
	begin : g_bad_pin_count
		$error("PIN_COUNT must be 28, 40, 44 or 64");
	end

	// package variant decides which pad bits exist and where serial 2 sits
	localparam logic [7:0] PAD_MASK = (PIN_COUNT == 64) ? PAD_MASK_64 :
	                                  (PIN_COUNT == 28) ? PAD_MASK_28 : PAD_MASK_44;
	localparam logic       SER2_HERE = (PIN_COUNT == 40 || PIN_COUNT == 44);

	// registers
	logic [7:0] out_latch_r;
	logic [7:0] direction_r;
	logic [7:0] pad_cfg_r;
	logic [7:0] open_drain_r;
	logic [7:0] analog_upper_r;
	logic [7:0] par_ctl_r;
	logic [7:0] pin_level_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	// apb decode
	logic        setup_ph;
	logic        wr_acc;
	logic        byte0_wr;
	logic        hit_lvl;
	logic        hit_lat;
	logic        hit_dir;
	logic        hit_pad;
	logic        hit_od;
	logic        hit_an;
	logic        hit_par;
	logic        mapped;
	logic [7:0]  rd_byte;

	assign setup_ph = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;
	assign byte0_wr = wr_acc && pstrb[0];
	assign hit_lvl  = (paddr == OFS_PIN_LEVELS);
	assign hit_lat  = (paddr == OFS_OUT_LATCH);
	assign hit_dir  = (paddr == OFS_DIRECTION);
	assign hit_pad  = (paddr == OFS_PAD_PULLUP);
	assign hit_od   = (paddr == OFS_OPEN_DRAIN);
	assign hit_an   = (paddr == OFS_ANALOG_UPPER);
	assign hit_par  = (paddr == OFS_PAR_PORT_CTL);
	assign mapped   = hit_lvl || hit_lat || hit_dir || hit_pad || hit_od || hit_an || hit_par;

	// read mux; missing pad bits read back as zero
	assign rd_byte = hit_lvl ? pin_level_r :
	                 hit_lat ? out_latch_r :
	                 hit_dir ? direction_r :
	                 hit_pad ? (pad_cfg_r & PAD_MASK) :
	                 hit_od  ? open_drain_r :
	                 hit_an  ? analog_upper_r :
	                 hit_par ? par_ctl_r : 8'h00;

	// answer is captured in setup so prdata comes from a flop; no wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (setup_ph)
		begin
			prdata_r  <= {24'h00_0000, rd_byte};
			pslverr_r <= !mapped;
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign pready  = 1'b1;

	// software registers; writes land only at the access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_latch_r    <= OUT_LATCH_RST;
			direction_r    <= DIRECTION_RST;
			pad_cfg_r      <= PAD_PULLUP_RST;
			open_drain_r   <= OPEN_DRAIN_RST;
			analog_upper_r <= ANALOG_UPPER_RST;
			par_ctl_r      <= PAR_PORT_CTL_RST;
		end
		else if (byte0_wr)
		begin
			if (hit_lvl || hit_lat)
				out_latch_r <= pwdata[7:0];
			if (hit_dir)
				direction_r <= pwdata[7:0];
			if (hit_pad)
				pad_cfg_r <= pwdata[7:0] & PAD_MASK;
			if (hit_od)
				open_drain_r <= pwdata[7:0];
			if (hit_an)
				analog_upper_r <= pwdata[7:0];
			if (hit_par)
				par_ctl_r <= pwdata[7:0] & PAR_CTL_MASK;
		end
	end

	// pad sampling
	pin_sampler #(
		.WIDTH   (8)
	) u_sampler (
		.pclk    (pclk),
		.presetn (presetn),
		.pad_in  (pad_in),
		.level_r (pin_level_r)
	);

	// function selection per upper pin
	logic [7:0] fn_sel;
	logic [7:0] fn_out;
	logic [7:0] fn_force;
	logic [7:0] fn_tri;
	logic [7:0] od_en;
	logic       ser_tx6;
	logic       ser_dt7;
	logic       pu_en;

	assign psp_mode = par_ctl_r[PAR_SLAVE_SEL_BIT];
	// pull-ups come up disabled; setting the bit turns them off
	assign pu_en    = PAD_MASK[PORT_D_PULLUP_BIT] && !pad_cfg_r[PORT_D_PULLUP_BIT];
	assign current_source_select = pad_cfg_r[CUR_SRC_SEL_BIT];

	// serial 2 wins over PWM on pins 6 and 7; PWM still works in other parts
	assign ser_tx6 = SER2_HERE && (s2_tx_en || s2_clk_out_en);
	assign ser_dt7 = SER2_HERE && s2_data_out_en;

	assign fn_sel[3:0]   = 4'h0;
	assign fn_out[3:0]   = 4'h0;
	assign fn_force[3:0] = 4'h0;
	assign fn_tri[3:0]   = 4'h0;
	assign od_en[3:0]    = 4'h0;

	// pin 4: PWM channel A has the pin before plain compare
	assign fn_sel[4]   = pwm_en[0] || ccp_out_en;
	assign fn_out[4]   = pwm_en[0] ? pwm_out[0] : ccp_out;
	assign fn_force[4] = 1'b0;
	assign fn_tri[4]   = pwm_en[0] && pwm_shutdown && pwm_tri_cfg[0];
	assign od_en[4]    = open_drain_r[OD_COMPARE1_BIT];

	// pin 5: PWM channel B
	assign fn_sel[5]   = pwm_en[1];
	assign fn_out[5]   = pwm_out[1];
	assign fn_force[5] = 1'b0;
	assign fn_tri[5]   = pwm_shutdown && pwm_tri_cfg[1];
	assign od_en[5]    = open_drain_r[OD_COMPARE1_BIT];

	// pin 6: serial transmit or sync clock, else PWM channel C
	assign fn_sel[6]   = ser_tx6 || pwm_en[2];
	assign fn_out[6]   = ser_tx6 ? (s2_tx_en ? s2_tx : s2_clk_out) : pwm_out[2];
	assign fn_force[6] = 1'b0;
	assign fn_tri[6]   = !ser_tx6 && pwm_shutdown && pwm_tri_cfg[2];
	assign od_en[6]    = ser_tx6 ? open_drain_r[OD_SERIAL2_BIT] : open_drain_r[OD_COMPARE1_BIT];

	// pin 7: sync data transmit drives whatever the direction bit says
	assign fn_sel[7]   = ser_dt7 || pwm_en[3];
	assign fn_out[7]   = ser_dt7 ? s2_data_out : pwm_out[3];
	assign fn_force[7] = ser_dt7;
	assign fn_tri[7]   = !ser_dt7 && pwm_shutdown && pwm_tri_cfg[3];
	assign od_en[7]    = ser_dt7 ? open_drain_r[OD_SERIAL2_BIT] : open_drain_r[OD_COMPARE1_BIT];

	// one pad cell per pin
	for (genvar i = 0; i < 8; i++)
	begin : g_pin
		port_pin_cell u_cell (
			.pclk         (pclk),
			.presetn      (presetn),
			.dir          (direction_r[i]),
			.latch        (out_latch_r[i]),
			.pullup_en    (pu_en),
			.open_drain   (od_en[i]),
			.psp_own      (psp_mode),
			.psp_drive    (psp_drive),
			.psp_out      (psp_data_out[i]),
			.fn_sel       (fn_sel[i]),
			.fn_out       (fn_out[i]),
			.fn_force     (fn_force[i]),
			.fn_tristate  (fn_tri[i]),
			.pad_out_r    (pad_out[i]),
			.pad_oe_r     (pad_oe[i]),
			.pad_pullup_r (pad_pullup[i])
		);
	end

	// inputs toward peripherals; capture and serial 2 gated by the direction bit, capture also by slave bus mode; slave bus data ungated
	assign capture_in  = direction_r[PIN_CAPTURE] && !psp_mode && pin_level_r[PIN_CAPTURE];
	assign s2_clk_in   = SER2_HERE && direction_r[PIN_TX_CLK] && pin_level_r[PIN_TX_CLK];
	assign s2_rx       = SER2_HERE && direction_r[PIN_RX_DATA] && pin_level_r[PIN_RX_DATA];
	assign s2_data_in  = SER2_HERE && direction_r[PIN_RX_DATA] && pin_level_r[PIN_RX_DATA];
	assign psp_data_in = pin_level_r;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_reset_inputs: assert property ($rose(presetn) |-> direction_r == DIRECTION_RST && pad_oe == 8'h00)
		else $error("pins not inputs after reset");

	a_latch_drive: assert property (!psp_mode && !direction_r[0] |=> pad_oe[0] && pad_out[0] == $past(out_latch_r[0]))
		else $error("latch not driven on output pin");

	a_pullup_off: assert property ((pad_oe & pad_pullup) == 8'h00)
		else $error("pull-up left on driving pin");

	a_bus_owns: assert property (psp_mode && psp_drive |=> pad_oe == 8'hff && pad_out == $past(psp_data_out))
		else $error("slave bus does not own the pins");

	a_bus_ignores_dir: assert property (psp_mode && !psp_drive |=> pad_oe == 8'h00)
		else $error("direction bits leak in slave bus mode");

	a_compare_out: assert property (!psp_mode && ccp_out_en && !pwm_en[0] && !direction_r[4] && !open_drain_r[2]
		|=> pad_oe[4] && pad_out[4] == $past(ccp_out))
		else $error("compare output not on pin 4");

	a_pwm_float: assert property (!psp_mode && pwm_en[1] && pwm_shutdown && pwm_tri_cfg[1] |=> !pad_oe[5])
		else $error("pin 5 driven during shutdown");

	a_pwm_d_float: assert property (!psp_mode && !ser_dt7 && pwm_en[3] && pwm_shutdown && pwm_tri_cfg[3]
		|=> !pad_oe[7])
		else $error("pin 7 driven during shutdown");

	a_serial_tx: assert property (!psp_mode && SER2_HERE && s2_tx_en && !direction_r[6] && !open_drain_r[1]
		|=> pad_oe[6] && pad_out[6] == $past(s2_tx))
		else $error("serial transmit not on pin 6");

	a_sync_data: assert property (!psp_mode && ser_dt7 && !open_drain_r[1]
		|=> pad_oe[7] && pad_out[7] == $past(s2_data_out))
		else $error("sync data not driven on pin 7");

	a_receive_path: assert property ($past(presetn) && direction_r[7] && $past(direction_r[7])
		|-> s2_rx == (SER2_HERE && $past(pad_in[7])))
		else $error("receive input does not follow pin 7");

	a_pad_readback: assert property (psel && penable && !pwrite && paddr == OFS_PAD_PULLUP
		|-> prdata[3:1] == 3'h0 && prdata[31:8] == 24'h00_0000)
		else $error("reserved pad bits read nonzero");

	a_port_write: assert property (psel && penable && pwrite && pstrb[0] && paddr == OFS_PIN_LEVELS
		|=> out_latch_r == $past(pwdata[7:0]))
		else $error("port write missed the latch");

	c_bus_mode: cover property (psp_mode && psp_drive ##1 pad_oe == 8'hff);
	c_pwm_shutdown: cover property (pwm_shutdown && pwm_tri_cfg[1] && pwm_en[1] ##1 !pad_oe[5]);
	c_serial_tx: cover property (ser_tx6 ##1 pad_oe[6]);
	c_bad_addr: cover property (psel && penable && pslverr);

endmodule : port_d_pin_function_mux

// ===== board_pad_model.sv
/*
 * Board side of the port pins: resolves each pin level from the pad drive,
 * an external driver and the weak pull-up.
 * Assumes one clock, pclk, and that the device wins any contention.
 */
`timescale 1ns/1ns
module board_pad_model
(
	// clock
	input  wire logic       pclk,
	// device pad side
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pullup,
	// external drivers
	input  wire logic [7:0] ext_drive,
	input  wire logic [7:0] ext_val,
	// resolved pin level
	output logic      [7:0] pad_in
);
	logic [7:0] float_r = 8'h55;

	// undriven pins wander, so a floating level never passes for data
	always_ff @(posedge pclk)
	begin
		float_r <= ~pad_in;
	end

	// device drive, then external drive, then pull-up, else floating
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pad_oe[i] === 1'b1)
				pad_in[i] = pad_out[i];
			else if (ext_drive[i] === 1'b1)
				pad_in[i] = ext_val[i];
			else if (pad_pullup[i] === 1'b1)
				pad_in[i] = 1'b1;
			else
				pad_in[i] = float_r[i];
		end
	end
endmodule : board_pad_model

// ===== port_d_pin_function_mux_bench.sv
/*
 * Self-checking bench for the port D pin multiplexer: apb register access,
 * pad drive, peripheral overrides and the parallel slave bus.
 * Assumes the board pad model closes the pad loop.
 */
`timescale 1ns/1ns
module port_d_pin_function_mux_bench
	import port_d_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup;
	logic        ccp_out_en = 1'b0, ccp_out = 1'b0, pwm_shutdown = 1'b0;
	logic [3:0]  pwm_en = 4'h0, pwm_out = 4'h0, pwm_tri_cfg = 4'h0;
	logic        capture_in, s2_rx, s2_clk_in, s2_data_in, psp_mode, current_source_select;
	logic        s2_tx_en = 1'b0, s2_tx = 1'b0, s2_clk_out_en = 1'b0, s2_clk_out = 1'b0;
	logic        s2_data_out_en = 1'b0, s2_data_out = 1'b0, psp_drive = 1'b0;
	logic [7:0]  psp_data_out = 8'h00, psp_data_in;
	logic [7:0]  ext_drive = 8'h00, ext_val = 8'h00, v;
	logic [31:0] rd;
	logic        er;
	int          errors = 0, num_checks = 0, cycles = 0;

	port_d_pin_function_mux u_port_d_pin_function_mux (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pullup), .ccp_out_en(ccp_out_en), .ccp_out(ccp_out), .pwm_en(pwm_en),
		.pwm_out(pwm_out), .pwm_shutdown(pwm_shutdown), .pwm_tri_cfg(pwm_tri_cfg),
		.capture_in(capture_in), .s2_tx_en(s2_tx_en), .s2_tx(s2_tx), .s2_clk_out_en(s2_clk_out_en),
		.s2_clk_out(s2_clk_out), .s2_data_out_en(s2_data_out_en), .s2_data_out(s2_data_out),
		.s2_rx(s2_rx), .s2_clk_in(s2_clk_in), .s2_data_in(s2_data_in), .psp_drive(psp_drive),
		.psp_data_out(psp_data_out), .psp_data_in(psp_data_in), .psp_mode(psp_mode),
		.current_source_select(current_source_select));

	board_pad_model u_board_pad_model (
		.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
		.ext_drive(ext_drive), .ext_val(ext_val), .pad_in(pad_in));

	// 25 MHz clock
	initial
	begin
		forever #20 pclk = ~pclk;
	end

	// verdict and end of run
	task complete_run;
		$display("Checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// hang guard, far above the length of the sequence
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			complete_run;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; an idle edge first keeps drivers single per step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 20)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, pready, 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'hf);
		chk(rd, exp);
	endtask : rdchk

	// registered pads need a couple of edges after a change
	task settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	initial
	begin
		repeat (12) @(posedge pclk);
		#1;
		chk(pad_oe, 8'h00);
		chk(pad_pullup, 8'h00);
		@(posedge pclk);
		presetn <= 1'b1;
		// values after reset
		rdchk(OFS_DIRECTION, 32'h000000ff);
		rdchk(OFS_OUT_LATCH, 32'h0);
		rdchk(OFS_PAD_PULLUP, 32'h00000080);
		rdchk(OFS_OPEN_DRAIN, 32'h0);
		rdchk(OFS_ANALOG_UPPER, 32'h0);
		rdchk(OFS_PAR_PORT_CTL, 32'h0);
		// unmapped place and a write with its strobe off
		apb(1'b1, 8'h1c, 32'hff, 4'hf);
		chk(er, 1'b1);
		apb(1'b0, 8'h1c, 32'h0, 4'hf);
		chk(rd, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, OFS_OUT_LATCH, 32'h5a, 4'h0);
		rdchk(OFS_OUT_LATCH, 32'h0);
		// absent pull-up bits and reserved bits read zero
		apb(1'b1, OFS_PAD_PULLUP, 32'hff, 4'hf);
		rdchk(OFS_PAD_PULLUP, 32'h000000c1);
		settle;
		chk(current_source_select, 1'b1);
		chk(pad_pullup, 8'h00);
		apb(1'b1, OFS_PAD_PULLUP, 32'h01, 4'hf);
		settle;
		chk(pad_pullup, 8'hff);
		// upper pins drive the latch, pull-ups leave them
		apb(1'b1, OFS_PIN_LEVELS, 32'h3c, 4'hf);
		rdchk(OFS_OUT_LATCH, 32'h3c);
		apb(1'b1, OFS_DIRECTION, 32'h0f, 4'hf);
		settle;
		chk(pad_oe, 8'hf0);
		chk(pad_out & 8'hf0, 8'h30);
		chk(pad_pullup, 8'h0f);
		rdchk(OFS_PIN_LEVELS, 32'h3f);
		// inputs reach pin levels and peripheral inputs
		apb(1'b1, OFS_DIRECTION, 32'hff, 4'hf);
		for (int k = 0; k < 2; k++)
		begin
			v = (k == 0) ? 8'h5a : 8'ha5;
			@(posedge pclk);
			ext_drive <= 8'hff;
			ext_val <= v;
			settle;
			rdchk(OFS_PIN_LEVELS, {24'h0, v});
			chk(capture_in, v[4]);
			chk(s2_clk_in, v[6]);
			chk(s2_rx, v[7]);
			chk(s2_data_in, v[7]);
		end
		// peripherals override a zero latch
		apb(1'b1, OFS_OUT_LATCH, 32'h0, 4'hf);
		apb(1'b1, OFS_DIRECTION, 32'h0, 4'hf);
		@(posedge pclk);
		ext_drive <= 8'h00;
		ccp_out_en <= 1'b1;
		ccp_out <= 1'b1;
		settle;
		chk(pad_out[4], 1'b1);
		@(posedge pclk);
		pwm_en <= 4'hf;
		pwm_out <= 4'ha;
		settle;
		chk(pad_out[7:4], 4'ha);
		chk(pad_oe[7:4], 4'hf);
		@(posedge pclk);
		pwm_shutdown <= 1'b1;
		pwm_tri_cfg <= 4'h3;
		settle;
		chk(pad_oe[7:4], 4'hc);
		@(posedge pclk);
		pwm_tri_cfg <= 4'hc;
		settle;
		chk(pad_oe[7:4], 4'h3);
		// serial transmit and clock beat pwm channel c
		@(posedge pclk);
		pwm_shutdown <= 1'b0;
		s2_tx_en <= 1'b1;
		s2_tx <= 1'b1;
		settle;
		chk(pad_out[6], 1'b1);
		@(posedge pclk);
		s2_tx_en <= 1'b0;
		s2_clk_out_en <= 1'b1;
		s2_clk_out <= 1'b1;
		settle;
		chk(pad_out[6], 1'b1);
		apb(1'b1, OFS_DIRECTION, 32'h80, 4'hf);
		@(posedge pclk);
		s2_data_out_en <= 1'b1;
		s2_data_out <= 1'b0;
		settle;
		chk(pad_oe[7], 1'b1);
		chk(pad_out[7], 1'b0);
		// open drain releases a high serial clock
		apb(1'b1, OFS_OPEN_DRAIN, 32'h02, 4'hf);
		settle;
		chk(pad_oe[6], 1'b0);
		// slave bus takes all pins whatever the direction bits say
		apb(1'b1, OFS_PAR_PORT_CTL, 32'hff, 4'hf);
		rdchk(OFS_PAR_PORT_CTL, 32'h10);
		@(posedge pclk);
		psp_drive <= 1'b1;
		psp_data_out <= 8'h96;
		settle;
		chk(psp_mode, 1'b1);
		chk(pad_oe, 8'hff);
		chk(pad_out, 8'h96);
		@(posedge pclk);
		psp_drive <= 1'b0;
		ext_drive <= 8'hff;
		ext_val <= 8'h3c;
		settle;
		chk(pad_oe, 8'h00);
		chk(psp_data_in, 8'h3c);
		complete_run;
	end
endmodule : port_d_pin_function_mux_bench
